/* hw/tvflc_top.v */
`timescale 1ns/1ps
`include "tvflc_consts.vh"
module tvflc_top
#(
  parameter CYC_PER_MS = `TVFLC_CLK_HZ / `TVFLC_MS_PER_S
)
(
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out_reg,
  output reg         sda_oe_reg,
  input  wire [15:0] temp_value,
  input  wire [15:0] vin_value,
  input  wire        output_on_pin,
  input  wire        fault_clear,
  output reg         alert_line_n,
  output reg         output_enable_reg,
  output reg  [3:0]  status_reg
);
  localparam [1:0] B_IDLE = 2'h0;
  localparam [1:0] B_RX   = 2'h1;
  localparam [1:0] B_TX   = 2'h2;
  localparam [1:0] B_START = 2'h3;

  reg  [2:0]  scl_s_reg;
  reg  [2:0]  sda_s_reg;
  reg  [1:0]  on_s_reg;
  reg  [1:0]  st_reg;
  reg  [3:0]  bit_reg;
  reg  [2:0]  byte_reg;
  reg  [7:0]  sh_reg;
  reg  [7:0]  cmd_reg;
  reg  [15:0] wbuf_reg;
  reg         rw_reg;
  reg         rd_hi_reg;
  reg  [15:0] ot_warn_reg;
  reg  [15:0] ut_warn_reg;
  reg  [15:0] ut_fault_reg;
  reg  [15:0] vin_ov_reg;
  reg  [7:0]  ut_act_reg;
  reg  [7:0]  vin_act_reg;
  reg  [31:0] ms_cnt_reg;
  reg         ms_tick_reg;
  reg  [3:0]  status_next;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_ev;
  wire        stop_ev;
  wire        sda_now;
  wire [3:0]  hit;
  wire        ut_ok;
  wire        vin_ok;
  wire [15:0] rd_val;

  // ****************************************
  // Command decode
  // ****************************************
  function is_word;
    input [7:0] c;
    begin
      is_word = (c == `TVFLC_CMD_OT_WARN) || (c == `TVFLC_CMD_UT_WARN) ||
                (c == `TVFLC_CMD_UT_FAULT) || (c == `TVFLC_CMD_VIN_OV);
    end
  endfunction

  function is_byte;
    input [7:0] c;
    begin
      is_byte = (c == `TVFLC_CMD_UT_ACTION) ||
                (c == `TVFLC_CMD_VIN_ACTION);
    end
  endfunction

  function [15:0] rd_word;
    input [7:0] c;
    begin
      case (c)
        `TVFLC_CMD_OT_WARN:    rd_word = ot_warn_reg;
        `TVFLC_CMD_UT_WARN:    rd_word = ut_warn_reg;
        `TVFLC_CMD_UT_FAULT:   rd_word = ut_fault_reg;
        `TVFLC_CMD_VIN_OV:     rd_word = vin_ov_reg;
        `TVFLC_CMD_UT_ACTION:  rd_word = {8'h00, ut_act_reg};
        `TVFLC_CMD_VIN_ACTION: rd_word = {8'h00, vin_act_reg};
        default:               rd_word = 16'hffff;
      endcase
    end
  endfunction
  assign rd_val = rd_word(cmd_reg);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      on_s_reg  <= 2'h0;
    end
    else
    begin
      scl_s_reg <= {scl_s_reg[1:0], scl_in};
      sda_s_reg <= {sda_s_reg[1:0], sda_in};
      on_s_reg  <= {on_s_reg[0], output_on_pin};
    end
  end

  // Only the second and third stages are looked at
  assign sda_now  = sda_s_reg[1];
  assign scl_rise = scl_s_reg[1] & ~scl_s_reg[2];
  assign scl_fall = ~scl_s_reg[1] & scl_s_reg[2];
  assign start_ev = scl_s_reg[1] & scl_s_reg[2] & ~sda_s_reg[1] &
                    sda_s_reg[2];
  assign stop_ev  = scl_s_reg[1] & scl_s_reg[2] & sda_s_reg[1] &
                    ~sda_s_reg[2];

  // ****************************************
  // Bus slave
  // ****************************************
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_reg       <= B_IDLE;
      bit_reg      <= 4'h0;
      byte_reg     <= 3'h0;
      sh_reg       <= 8'h00;
      cmd_reg      <= 8'h00;
      wbuf_reg     <= 16'h0000;
      rw_reg       <= 1'b0;
      rd_hi_reg    <= 1'b0;
      sda_out_reg  <= 1'b0;
      sda_oe_reg   <= 1'b0;
      ot_warn_reg  <= `TVFLC_RST_OT_WARN;
      ut_warn_reg  <= `TVFLC_RST_UT_WARN;
      ut_fault_reg <= `TVFLC_RST_UT_FAULT;
      vin_ov_reg   <= `TVFLC_RST_VIN_OV;
      ut_act_reg   <= `TVFLC_RST_ACTION;
      vin_act_reg  <= `TVFLC_RST_ACTION;
    end
    else if (start_ev)
    begin
      // Repeated start keeps the command for the read
      st_reg     <= B_START;
      bit_reg    <= 4'h0;
      byte_reg   <= 3'h0;
      rd_hi_reg  <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (stop_ev)
    begin
      st_reg     <= B_IDLE;
      sda_oe_reg <= 1'b0;
      if (!rw_reg && is_word(cmd_reg) && byte_reg == 3'h4)
      begin
        case (cmd_reg)
          `TVFLC_CMD_OT_WARN:  ot_warn_reg  <= wbuf_reg;
          `TVFLC_CMD_UT_WARN:  ut_warn_reg  <= wbuf_reg;
          `TVFLC_CMD_UT_FAULT: ut_fault_reg <= wbuf_reg;
          default:             vin_ov_reg   <= wbuf_reg;
        endcase
      end
      if (!rw_reg && is_byte(cmd_reg) && byte_reg == 3'h3)
      begin
        if (cmd_reg == `TVFLC_CMD_UT_ACTION)
          ut_act_reg <= wbuf_reg[7:0];
        else
          vin_act_reg <= wbuf_reg[7:0];
      end
    end
    else if (st_reg == B_START)
    begin
      // The clock fall that closes a start carries no bit
      st_reg <= scl_fall ? B_RX : B_START;
    end
    else if (st_reg == B_RX)
    begin
      if (scl_rise && bit_reg != 4'h8)
        sh_reg <= {sh_reg[6:0], sda_now};
      if (scl_fall && bit_reg == 4'h7)
      begin
        bit_reg <= 4'h8;
        case (byte_reg)
          3'h0:
          begin
            if (sh_reg[7:1] == `TVFLC_SLAVE_ADDR)
            begin
              rw_reg     <= sh_reg[0];
              sda_oe_reg <= 1'b1;
            end
            else
              st_reg <= B_IDLE;
          end
          3'h1:
          begin
            cmd_reg <= sh_reg;
            if (is_word(sh_reg) || is_byte(sh_reg))
              sda_oe_reg <= 1'b1;
            else
              st_reg <= B_IDLE;
          end
          3'h2:
          begin
            wbuf_reg[7:0] <= sh_reg;
            sda_oe_reg    <= 1'b1;
          end
          3'h3:
          begin
            // A byte action takes no second data byte
            wbuf_reg[15:8] <= sh_reg;
            if (is_word(cmd_reg))
              sda_oe_reg <= 1'b1;
            else
              st_reg <= B_IDLE;
          end
          default: st_reg <= B_IDLE;
        endcase
      end
      else if (scl_fall && bit_reg == 4'h8)
      begin
        bit_reg    <= 4'h0;
        byte_reg   <= byte_reg + 3'h1;
        sda_oe_reg <= 1'b0;
        if (rw_reg && byte_reg == 3'h0)
        begin
          st_reg     <= B_TX;
          sh_reg     <= rd_val[7:0];
          sda_oe_reg <= ~rd_val[7];
        end
      end
      else if (scl_fall)
        bit_reg <= bit_reg + 4'h1;
    end
    else if (st_reg == B_TX)
    begin
      if (scl_fall && bit_reg < 4'h7)
      begin
        bit_reg    <= bit_reg + 4'h1;
        sh_reg     <= {sh_reg[6:0], 1'b1};
        sda_oe_reg <= ~sh_reg[6];
      end
      else if (scl_fall && bit_reg == 4'h7)
      begin
        bit_reg    <= 4'h8;
        sda_oe_reg <= 1'b0;
      end
      else if (scl_rise && bit_reg == 4'h8)
      begin
        // Host nack ends the read; only a word yields a high byte
        if (sda_now || rd_hi_reg || !is_word(cmd_reg))
          st_reg <= B_IDLE;
        else
        begin
          rd_hi_reg <= 1'b1;
          sh_reg    <= rd_val[15:8];
        end
      end
      else if (scl_fall && bit_reg == 4'h8)
      begin
        bit_reg    <= 4'h0;
        sda_oe_reg <= ~sh_reg[7];
      end
    end
  end

  // ****************************************
  // Millisecond tick
  // ****************************************
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      ms_cnt_reg  <= 32'h00000000;
      ms_tick_reg <= 1'b0;
    end
    else if (ms_cnt_reg == CYC_PER_MS - 1)
    begin
      ms_cnt_reg  <= 32'h00000000;
      ms_tick_reg <= 1'b1;
    end
    else
    begin
      ms_cnt_reg  <= ms_cnt_reg + 32'h00000001;
      ms_tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // Limit compare and status
  // ****************************************
  // Both sides taken as signed codes of one scale
  assign hit[0] = $signed(temp_value) > $signed(ot_warn_reg);
  assign hit[1] = $signed(temp_value) < $signed(ut_warn_reg);
  assign hit[2] = $signed(temp_value) < $signed(ut_fault_reg);
  assign hit[3] = $signed(vin_value) > $signed(vin_ov_reg);

  always @*
  begin
    // Set beats clear in the same cycle
    status_next = (status_reg & {4{~fault_clear}}) | hit;
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      status_reg        <= 4'h0;
      alert_line_n      <= 1'b1;
      output_enable_reg <= 1'b0;
    end
    else
    begin
      status_reg        <= status_next;
      alert_line_n      <= ~|status_next;
      // Warnings do not gate the output
      output_enable_reg <= on_s_reg[1] & ut_ok & vin_ok;
    end
  end

  // ****************************************
  // Fault responses
  // ****************************************
  tvflc_fault_resp u_ut_resp
  (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .fault_hit   (hit[2]),
    .action      (ut_act_reg),
    .ms_tick     (ms_tick_reg),
    .run_cmd     (on_s_reg[1]),
    .fault_clear (fault_clear),
    .out_ok_reg  (ut_ok)
  );

  tvflc_fault_resp u_vin_resp
  (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .fault_hit   (hit[3]),
    .action      (vin_act_reg),
    .ms_tick     (ms_tick_reg),
    .run_cmd     (on_s_reg[1]),
    .fault_clear (fault_clear),
    .out_ok_reg  (vin_ok)
  );
endmodule // tvflc_top

/* hw/tvflc_consts.vh */
`ifndef TVFLC_CONSTS_VH
`define TVFLC_CONSTS_VH
// ****************************************
// Command codes
// ****************************************
`define TVFLC_CMD_OT_WARN    8'h51
`define TVFLC_CMD_UT_WARN    8'h52
`define TVFLC_CMD_UT_FAULT   8'h53
`define TVFLC_CMD_UT_ACTION  8'h54
`define TVFLC_CMD_VIN_OV     8'h55
`define TVFLC_CMD_VIN_ACTION 8'h56
// ****************************************
// Reset values
// ****************************************
`define TVFLC_RST_OT_WARN    16'h7fff
`define TVFLC_RST_UT_WARN    16'h8000
`define TVFLC_RST_UT_FAULT   16'h8000
`define TVFLC_RST_VIN_OV     16'h7fff
`define TVFLC_RST_ACTION     8'h80
// ****************************************
// Action byte fields
// ****************************************
`define TVFLC_MODE_HI        7
`define TVFLC_MODE_LO        6
`define TVFLC_CNT_HI         5
`define TVFLC_CNT_LO         3
`define TVFLC_DLY_HI         2
`define TVFLC_DLY_LO         0
`define TVFLC_MODE_RETRY     2'h2
`define TVFLC_CNT_NONE       3'h0
`define TVFLC_CNT_ENDLESS    3'h7
// ****************************************
// Timing and bus address
// ****************************************
`define TVFLC_CLK_HZ         200000000
`define TVFLC_MS_PER_S       1000
`define TVFLC_RETRY_STEP_MS  35
`define TVFLC_SLAVE_ADDR     7'h40
`endif

/* hw/tvflc_fault_resp.v */
`timescale 1ns/1ps
`include "tvflc_consts.vh"
module tvflc_fault_resp
(
  input  wire       clock,
  input  wire       sys_rst,
  input  wire       fault_hit,
  input  wire [7:0] action,
  input  wire       ms_tick,
  input  wire       run_cmd,
  input  wire       fault_clear,
  output reg        out_ok_reg
);
  localparam [1:0] S_RUN  = 2'h0;
  localparam [1:0] S_WAIT = 2'h1;
  localparam [1:0] S_HOLD = 2'h2;

  reg  [1:0] st_reg;
  reg  [2:0] rem_reg;
  reg        fresh_reg;
  reg  [8:0] dly_reg;
  wire [2:0] cnt_now;

  // ****************************************
  // Delay in whole milliseconds
  // ****************************************
  function [8:0] delay_ms;
    input [2:0] v;
    reg   [31:0] prod;
    begin
      prod     = ({29'h0, v} + 32'h00000001) * `TVFLC_RETRY_STEP_MS;
      // Longest delay is 280 ms, so nine bits hold it
      delay_ms = prod[8:0];
    end
  endfunction

  // First fault uses the field, later ones the remainder
  assign cnt_now = fresh_reg ? action[`TVFLC_CNT_HI:`TVFLC_CNT_LO]
                             : rem_reg;

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_reg     <= S_RUN;
      out_ok_reg <= 1'b1;
      rem_reg    <= 3'h0;
      fresh_reg  <= 1'b1;
      dly_reg    <= 9'h000;
    end
    else
    begin
      case (st_reg)
        S_RUN:
        begin
          if (fault_hit && run_cmd &&
              action[`TVFLC_MODE_HI:`TVFLC_MODE_LO] == `TVFLC_MODE_RETRY)
          begin
            out_ok_reg <= 1'b0;
            fresh_reg  <= 1'b0;
            if (cnt_now == `TVFLC_CNT_NONE)
              st_reg <= S_HOLD;
            else
            begin
              // Endless count never runs down
              if (cnt_now == `TVFLC_CNT_ENDLESS)
                rem_reg <= `TVFLC_CNT_ENDLESS;
              else
                rem_reg <= cnt_now - 3'h1;
              dly_reg <= delay_ms(action[`TVFLC_DLY_HI:`TVFLC_DLY_LO]);
              st_reg  <= S_WAIT;
            end
          end
          else if (fault_clear)
            fresh_reg <= 1'b1;
        end
        S_WAIT:
        begin
          if (!run_cmd)
          begin
            // Commanded off ends the retry sequence
            st_reg     <= S_RUN;
            out_ok_reg <= 1'b1;
            fresh_reg  <= 1'b1;
          end
          else if (ms_tick)
          begin
            if (dly_reg == 9'h001)
            begin
              st_reg     <= S_RUN;
              out_ok_reg <= 1'b1;
            end
            else
              dly_reg <= dly_reg - 9'h001;
          end
        end
        S_HOLD:
        begin
          if (fault_clear && !fault_hit)
          begin
            st_reg     <= S_RUN;
            out_ok_reg <= 1'b1;
            fresh_reg  <= 1'b1;
          end
        end
        default:
        begin
          st_reg     <= S_RUN;
          out_ok_reg <= 1'b1;
        end
      endcase
    end
  end
endmodule // tvflc_fault_resp

/* tb/tvflc_chk.sv */
`timescale 1ns/1ps
module tvflc_chk
#(
  parameter CYC_PER_MS = 20
)
(
  input wire        clock,
  input wire        sys_rst,
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_out_reg,
  input wire        sda_oe_reg,
  input wire [15:0] temp_value,
  input wire [15:0] vin_value,
  input wire        output_on_pin,
  input wire        fault_clear,
  input wire        alert_line_n,
  input wire        output_enable_reg,
  input wire [3:0]  status_reg
);
  // ****
  // Off time counter
  // ****
  // Cleared when the pin drops, so an aborted retry is not timed
  integer off_cnt;
  always @(posedge clock)
  begin
    if (sys_rst || output_enable_reg || !output_on_pin)
      off_cnt <= 0;
    else if (off_cnt < 100000)
      off_cnt <= off_cnt + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_alert;
    alert_line_n == (status_reg == 4'h0);
  endproperty
  property p_sticky;
    !fault_clear |=> (status_reg & $past(status_reg)) == $past(status_reg);
  endproperty
  property p_fall;
    $fell(output_enable_reg) |-> status_reg[3:2] != 2'b00 || !output_on_pin;
  endproperty
  property p_rise;
    $rose(output_enable_reg) |-> output_on_pin && $past(output_on_pin, 2);
  endproperty
  property p_off;
    !output_on_pin [*4] |-> !output_enable_reg;
  endproperty
  property p_drain;
    sda_out_reg == 1'b0;
  endproperty
  property p_sda_phase;
    $changed(sda_oe_reg) |-> !scl_in && !$past(scl_in);
  endproperty
  property p_gap;
    $rose(output_enable_reg) && status_reg[3:2] != 2'b00 && off_cnt > 8
      |-> off_cnt >= 34 * CYC_PER_MS;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert disagrees with status");
  a_sticky: assert property (p_sticky)
    else $error("status bit lost without clear");
  a_fall: assert property (p_fall)
    else $error("output dropped without fault");
  a_rise: assert property (p_rise)
    else $error("output rose while not commanded");
  a_off: assert property (p_off)
    else $error("output on while commanded off");
  a_drain: assert property (p_drain)
    else $error("data pin driven high");
  a_sda_phase: assert property (p_sda_phase)
    else $error("data pin moved while clock high");
  a_gap: assert property (p_gap)
    else $error("restart came too early");
  c_vin: cover property ($rose(status_reg[3]));
  c_ut: cover property ($rose(status_reg[2]));
  c_retry: cover property ($rose(output_enable_reg) && status_reg != 4'h0);
  c_ack: cover property ($rose(sda_oe_reg));
endmodule // tvflc_chk

bind tvflc_top tvflc_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk
(
  .clock(clock), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out_reg(sda_out_reg), .sda_oe_reg(sda_oe_reg),
  .temp_value(temp_value), .vin_value(vin_value),
  .output_on_pin(output_on_pin), .fault_clear(fault_clear),
  .alert_line_n(alert_line_n), .output_enable_reg(output_enable_reg),
  .status_reg(status_reg)
);

/* tb/tvflc_host.sv */
`timescale 1ns/1ps
`include "tvflc_consts.vh"
module tvflc_host
(
  input  wire clock,
  input  wire sda,
  output reg  scl,
  output reg  sda_o
);
  // ****
  // Bus host, 32 clocks a bit
  // ****
  reg nak;
  reg a_last;
  initial
  begin
    scl = 1'b1;
    sda_o = 1'b1;
    nak = 1'b0;
    a_last = 1'b0;
  end
  task hc(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task bitx(input b, output r);
  begin
    sda_o <= b;
    hc(8);
    scl <= 1'b1;
    hc(8);
    r = sda;
    hc(8);
    scl <= 1'b0;
    hc(8);
  end
  endtask
  task xfer(input [7:0] d, input ak, output [7:0] r);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bitx(d[i], r[i]);
    bitx(ak, a_last);
    if (ak)
      nak = nak | a_last;
  end
  endtask
  task sr;
  begin
    sda_o <= 1'b1;
    hc(8);
    scl <= 1'b1;
    hc(16);
    sda_o <= 1'b0;
    hc(16);
    scl <= 1'b0;
    hc(8);
  end
  endtask
  task sp;
  begin
    sda_o <= 1'b0;
    hc(8);
    scl <= 1'b1;
    hc(16);
    sda_o <= 1'b1;
    hc(16);
  end
  endtask
  task wr(input [7:0] c, input [1:0] n, input [15:0] d);
    reg [7:0] r;
  begin
    nak = 1'b0;
    sr;
    xfer({`TVFLC_SLAVE_ADDR, 1'b0}, 1'b1, r);
    xfer(c, 1'b1, r);
    xfer(d[7:0], 1'b1, r);
    if (n == 2'd2)
      xfer(d[15:8], 1'b1, r);
    sp;
  end
  endtask
  task rd(input [7:0] c, input [1:0] n, output [15:0] q);
    reg [7:0] r;
    reg       k;
  begin
    nak = 1'b0;
    q = 16'h0000;
    sr;
    xfer({`TVFLC_SLAVE_ADDR, 1'b0}, 1'b1, r);
    xfer(c, 1'b1, r);
    sr;
    xfer({`TVFLC_SLAVE_ADDR, 1'b1}, 1'b1, r);
    k = nak;
    if (n == 2'd2)
    begin
      xfer(8'hff, 1'b0, q[7:0]);
      xfer(8'hff, 1'b1, q[15:8]);
    end
    else
      xfer(8'hff, 1'b1, q[7:0]);
    nak = k;
    sp;
  end
  endtask
endmodule // tvflc_host

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "tvflc_consts.vh"
module testbench;
  reg         clock;
  reg         sys_rst;
  reg  [15:0] temp_value;
  reg  [15:0] vin_value;
  reg         output_on_pin;
  reg         fault_clear;
  wire        scl;
  wire        sda_o;
  wire        sda_out_reg;
  wire        sda_oe_reg;
  wire        alert_line_n;
  wire        output_enable_reg;
  wire [3:0]  status_reg;
  wire        sda_w = sda_o & ~sda_oe_reg;
  integer     fail_count;
  integer     num_checks;
  integer     cyc;
  integer     i;
  reg  [15:0] q;
  tvflc_top #(.CYC_PER_MS(20)) u_dut
  (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_w),
    .sda_out_reg(sda_out_reg), .sda_oe_reg(sda_oe_reg),
    .temp_value(temp_value), .vin_value(vin_value),
    .output_on_pin(output_on_pin), .fault_clear(fault_clear),
    .alert_line_n(alert_line_n), .output_enable_reg(output_enable_reg),
    .status_reg(status_reg)
  );
  tvflc_host u_host
  (
    .clock(clock), .sda(sda_w), .scl(scl), .sda_o(sda_o)
  );
  // ****
  // Checks and verdict
  // ****
  task chk(input [15:0] got, input [15:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task results;
  begin
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  function [15:0] rstv(input integer k);
    case (k)
      0:       rstv = `TVFLC_RST_OT_WARN;
      1:       rstv = `TVFLC_RST_UT_WARN;
      2:       rstv = `TVFLC_RST_UT_FAULT;
      4:       rstv = `TVFLC_RST_VIN_OV;
      default: rstv = {8'h00, `TVFLC_RST_ACTION};
    endcase
  endfunction
  // Fault, retries, then removal and clear
  task frun(input ut, input [2:0] n, input [2:0] d);
    integer   t, r, f, first;
    reg [7:0] c;
  begin
    c = ut ? `TVFLC_CMD_UT_ACTION : `TVFLC_CMD_VIN_ACTION;
    u_host.wr(c, 2'd1, {8'h00, 2'b10, n, d});
    u_host.rd(c, 2'd1, q);
    chk(q, {8'h00, 2'b10, n, d});
    if (ut)
      temp_value <= 16'hfff0;
    else
      vin_value <= 16'h0200;
    repeat (3) @(posedge clock);
    #1;
    chk({12'h0, alert_line_n, output_enable_reg, status_reg[3:2]},
        {14'h0, ~ut, ut});
    t = 0;
    r = 0;
    f = 0;
    first = 0;
    while (t < 4 * (d + 1) * 705 + 200)
    begin
      @(posedge clock);
      #1;
      t = t + 1;
      if (output_enable_reg && f == 0)
      begin
        r = r + 1;
        if (r == 1)
          first = t;
      end
      f = output_enable_reg;
    end
    chk(r[15:0], (n > 3'd4) ? 16'd4 : {13'h0, n});
    if (n != 3'd0)
      chk({15'h0, first >= (d + 1) * 700 - 25 &&
        first <= (d + 1) * 700 + 10}, 16'h0001);
    @(posedge clock);
    temp_value <= 16'h0030;
    vin_value <= 16'h0000;
    repeat (1500) @(posedge clock);
    #1;
    chk({15'h0, output_enable_reg}, {15'h0, n == 3'd7});
    @(posedge clock);
    fault_clear <= 1'b1;
    @(posedge clock);
    fault_clear <= 1'b0;
    repeat (10) @(posedge clock);
    #1;
    chk({10'h0, alert_line_n, output_enable_reg, status_reg},
        16'h0030);
  end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Run is about 60k cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fail_count = fail_count + 1;
      results;
    end
  end
  initial
  begin
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    sys_rst = 1'b1;
    temp_value = 16'h0030;
    vin_value = 16'h0000;
    output_on_pin = 1'b0;
    fault_clear = 1'b0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    chk({10'h0, alert_line_n, output_enable_reg, status_reg},
        16'h0020);
    for (i = 0; i < 6; i = i + 1)
    begin
      u_host.rd(8'h51 + i[7:0], (i == 3 || i == 5) ? 2'd1 : 2'd2, q);
      chk(q, rstv(i));
    end
    u_host.wr(`TVFLC_CMD_OT_WARN, 2'd2, 16'h0050);
    u_host.wr(`TVFLC_CMD_UT_WARN, 2'd2, 16'h0020);
    u_host.wr(`TVFLC_CMD_UT_FAULT, 2'd2, 16'h0010);
    u_host.wr(`TVFLC_CMD_VIN_OV, 2'd2, 16'h0100);
    u_host.wr(`TVFLC_CMD_VIN_OV, 2'd1, 16'h00aa);
    u_host.rd(`TVFLC_CMD_VIN_OV, 2'd2, q);
    chk(q, 16'h0100);
    u_host.rd(`TVFLC_CMD_UT_FAULT, 2'd2, q);
    chk(q, 16'h0010);
    u_host.wr(8'h57, 2'd2, 16'h1234);
    chk({15'h0, u_host.nak}, 16'h0001);
    @(posedge clock);
    output_on_pin <= 1'b1;
    repeat (6) @(posedge clock);
    temp_value <= 16'h0060;
    repeat (5) @(posedge clock);
    #1;
    chk({10'h0, alert_line_n, output_enable_reg, status_reg},
        16'h0011);
    @(posedge clock);
    temp_value <= 16'h0030;
    fault_clear <= 1'b1;
    @(posedge clock);
    fault_clear <= 1'b0;
    frun(1'b0, 3'd0, 3'd0);
    frun(1'b1, 3'd1, 3'd2);
    frun(1'b0, 3'd2, 3'd0);
    frun(1'b1, 3'd7, 3'd1);
    // Mode 00 only flags the fault, output stays on
    u_host.wr(`TVFLC_CMD_VIN_ACTION, 2'd1, 16'h003f);
    vin_value <= 16'h0200;
    repeat (5) @(posedge clock);
    #1;
    chk({10'h0, alert_line_n, output_enable_reg, status_reg},
        16'h0018);
    @(posedge clock);
    vin_value <= 16'h0000;
    fault_clear <= 1'b1;
    @(posedge clock);
    fault_clear <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    chk({10'h0, alert_line_n, output_enable_reg, status_reg},
        16'h0030);
    results;
  end
endmodule // testbench
